// *** rtl/rpu_patch_unit.sv ***
module rpu_patch_unit #(
   parameter int N = 8
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [31:0] rom_rdata,
   output logic      [31:0] rom_patched_rdata,
   output logic      [7:0]  active_flags
);
   // ****************************************
   // Bus address phase capture
   // ****************************************
   logic        wr_pend_ff;
   logic        rd_pend_ff;
   logic [9:0]  addr_ph_ff;
   logic        rom_ph_ff;
   logic [31:0] rom_addr_ff;
   logic [N-1:0] active_ff;
   logic [N-1:0] addr_wr_ff;
   logic [N-1:0] data_wr_ff;
   logic [N-1:0] nxt_active;
   logic [N-1:0] nxt_addr_wr;
   logic [N-1:0] nxt_data_wr;
   logic [31:0]  mem_rd;
   logic [N*64-1:0] words;

   wire valid_tr   = hready && htrans[1];
   // Window decode for the register space
   wire in_regs    = haddr >= rpu_pkg::REG_BASE && haddr <= rpu_pkg::REG_LAST;
   wire reg_sel    = valid_tr && hsel && in_regs;
   // ROM image and alias both eligible
   wire in_rom     = haddr <= rpu_pkg::ROM_LAST
                  || (haddr >= rpu_pkg::ALIAS_BASE
                      && haddr <= rpu_pkg::ALIAS_LAST);

   // Single bus clock domain
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wr_pend_ff  <= 1'b0;
         rd_pend_ff  <= 1'b0;
         addr_ph_ff  <= 10'h000;
         rom_ph_ff   <= 1'b0;
         rom_addr_ff <= 32'h0000_0000;
      end else if (hready) begin
         wr_pend_ff  <= reg_sel && hwrite;
         rd_pend_ff  <= reg_sel && !hwrite;
         addr_ph_ff  <= haddr[9:0];
         rom_ph_ff   <= valid_tr && !hwrite && in_rom;
         rom_addr_ff <= haddr;
      end
   end

   // ****************************************
   // Register decode
   // ****************************************
   wire        is_entry   = addr_ph_ff < rpu_pkg::OFF_ACTIVE;
   wire [3:0]  word_idx   = addr_ph_ff[5:2];
   wire [2:0]  ent_idx    = word_idx[3:1];
   wire        is_data    = word_idx[0];
   wire        mem_wr     = wr_pend_ff && is_entry;
   wire        dis_wr     = wr_pend_ff && addr_ph_ff == rpu_pkg::OFF_DISABLE;
   wire        ena_wr     = wr_pend_ff && addr_ph_ff == rpu_pkg::OFF_ENABLE;
   // Read address taken in address phase so data is ready next cycle
   wire [3:0]  rd_word    = haddr[5:2];

   // Pairs stored address then data
   rpu_entry_mem #(.DEPTH(2*N)) u_mem (
      .core_clk   (core_clk),
      .wr_en      (mem_wr),
      .wr_idx     (word_idx),
      .wr_data    (hwdata),
      .rd_idx     (rd_word),
      .rd_data_ff (mem_rd),
      .all_words  (words)
   );

   // ****************************************
   // Active flag tracking
   // ****************************************
   function automatic logic [N-1:0] onehot(input logic [2:0] i,
                                           input logic en);
      onehot = en ? (N)'(1) << i : '0;
   endfunction : onehot

   wire [N-1:0] addr_hit = onehot(ent_idx, mem_wr && !is_data);
   wire [N-1:0] data_hit = onehot(ent_idx, mem_wr && is_data);
   // Data write after address arms the entry
   wire [N-1:0] arm      = data_hit & (addr_wr_ff | addr_hit);
   // Set beats disable strobe in same cycle
   wire [N-1:0] clr_v    = dis_wr ? hwdata[N-1:0] : '0;
   wire [N-1:0] set_v    = ena_wr ? hwdata[N-1:0] : '0;

   assign nxt_addr_wr = (addr_wr_ff | addr_hit) & ~arm;
   assign nxt_data_wr = data_wr_ff;
   assign nxt_active  = (active_ff & ~clr_v) | set_v | arm;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         active_ff  <= rpu_pkg::ACTIVE_RESET;
         addr_wr_ff <= '0;
         data_wr_ff <= '0;
      end else begin
         active_ff  <= nxt_active;
         addr_wr_ff <= nxt_addr_wr;
         data_wr_ff <= nxt_data_wr;
      end
   end

   // ****************************************
   // Parallel compare and priority
   // ****************************************
   function automatic logic [3:0] pick(input logic [N*64-1:0] w,
                                       input logic [N-1:0] act,
                                       input logic [31:0] a);
      pick = 4'h0;
      for (int k = 0; k < N; k++) begin
         if (act[k] && w[k*64 +: 32] == a) begin
            pick = {1'b1, 3'(k)};
         end
      end
   endfunction : pick

   wire [3:0]  hit      = pick(words, active_ff, rom_addr_ff);
   wire [31:0] sub_word = words[{hit[2:0], 1'b1}*32 +: 32];
   wire        do_sub   = rom_ph_ff && hit[3];

   // Combinational mux: no wait state added
   assign rom_patched_rdata = do_sub ? sub_word : rom_rdata;

   // ****************************************
   // Register read data
   // ****************************************
   wire [31:0] flags_rd = {24'h00_0000, active_ff};
   assign hrdata    = !rd_pend_ff ? 32'h0000_0000 :
                      is_entry ? mem_rd :
                      addr_ph_ff == rpu_pkg::OFF_ACTIVE ? flags_rd :
                      32'h0000_0000;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign active_flags = active_ff;

   // ****************************************
   // Checks
   // ****************************************
   a_reset_clears: assert property (@(posedge core_clk)
      !rst_n |=> active_ff == 8'h00) else $error("flags not cleared");
   a_pair_arms: assert property (@(posedge core_clk) disable iff (!rst_n)
      mem_wr && is_data && addr_wr_ff[ent_idx] && !dis_wr
      |=> active_ff[$past(ent_idx)]) else $error("entry not armed");
   a_disable_clears: assert property (@(posedge core_clk)
      disable iff (!rst_n) dis_wr && !ena_wr && !mem_wr
      |=> (active_ff & $past(hwdata[7:0])) == 8'h00)
      else $error("disable failed");
   a_enable_sets: assert property (@(posedge core_clk)
      disable iff (!rst_n) ena_wr
      |=> (active_ff & $past(hwdata[7:0])) == $past(hwdata[7:0]))
      else $error("enable failed");
   a_zero_keeps: assert property (@(posedge core_clk)
      disable iff (!rst_n) !wr_pend_ff |=> active_ff == $past(active_ff))
      else $error("flags changed without write");
   a_pass_through: assert property (@(posedge core_clk)
      disable iff (!rst_n) !do_sub |-> rom_patched_rdata == rom_rdata)
      else $error("data altered without match");
   a_top_wins: assert property (@(posedge core_clk)
      disable iff (!rst_n) rom_ph_ff && active_ff[7]
      && words[31:0] != 32'h0 && words[7*64 +: 32] == rom_addr_ff
      |-> rom_patched_rdata == words[7*64+32 +: 32])
      else $error("priority wrong");
   a_no_wait: assert property (@(posedge core_clk)
      disable iff (!rst_n) hreadyout) else $error("wait inserted");
   a_sub_match: assert property (@(posedge core_clk)
      disable iff (!rst_n) do_sub
      |-> active_ff[hit[2:0]] && words[hit[2:0]*64 +: 32] == rom_addr_ff)
      else $error("bad substitution");

   c_patch: cover property (@(posedge core_clk) do_sub);
   c_arm: cover property (@(posedge core_clk) |arm);
   c_disable: cover property (@(posedge core_clk) dis_wr);
   c_flag_read: cover property (@(posedge core_clk)
      rd_pend_ff && !is_entry);
endmodule : rpu_patch_unit

// *** rtl/rpu_pkg.sv ***
// Functional notes
// - Mux patch word onto ROM read data
// - Eight entries, address and data words
// - Data written after address sets entry active flag
// - Compare bus address with all entries
// - Match on enabled entry substitutes word
// - Highest matching entry index wins
// - Disable strobe ones clear active flags
// - Enable strobe ones set active flags
// - All registers reachable over system bus
// - Everything runs on system bus clock
// - Registers decode in their address window
// - ROM image and its alias patched
package rpu_pkg;
   // ****************************************
   // Address map
   // ****************************************
   localparam logic [31:0] REG_BASE     = 32'h4000_8400;
   localparam logic [31:0] REG_LAST     = 32'h4000_87FF;
   localparam logic [31:0] ROM_LAST     = 32'h0001_4FFF;
   localparam logic [31:0] ALIAS_BASE   = 32'h0002_0000;
   localparam logic [31:0] ALIAS_LAST   = 32'h0003_4FFF;
   localparam int          NUM_ENTRIES  = 8;
   // ****************************************
   // Register word offsets (byte addresses)
   // ****************************************
   localparam logic [9:0]  OFF_ENTRY0   = 10'h000;
   localparam logic [9:0]  OFF_ACTIVE   = 10'h040;
   localparam logic [9:0]  OFF_DISABLE  = 10'h044;
   localparam logic [9:0]  OFF_ENABLE   = 10'h048;
   localparam logic [7:0]  ACTIVE_RESET = 8'h00;
   localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
endpackage : rpu_pkg

// *** rtl/rpu_entry_mem.sv ***
module rpu_entry_mem #(
   parameter int DEPTH = 16
) (
   input  wire logic                     core_clk,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input  wire logic [31:0]              wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic      [31:0]              rd_data_ff,
   output logic      [DEPTH*32-1:0]      all_words
);
   // ****************************************
   // Entry storage, not reset: contents lost at power-up
   // ****************************************
   logic [31:0] mem_ff [DEPTH];

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem_ff[wr_idx] <= wr_data;
      end
      rd_data_ff <= mem_ff[rd_idx];
   end

   for (genvar g = 0; g < DEPTH; g++) begin : g_flat
      assign all_words[g*32 +: 32] = mem_ff[g];
   end
endmodule : rpu_entry_mem

// *** verif/rpu_rom_model.sv ***
module rpu_rom_model (
   input  wire logic        core_clk,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hready,
   output logic      [31:0] rom_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] a_ff    = 32'h0;
   logic [31:0] spin_ff = 32'h0;
   logic        ph_ff   = 1'b0;
   always @(posedge core_clk) begin
      ph_ff   <= hready && htrans[1];
      a_ff    <= haddr;
      spin_ff <= spin_ff + 32'h9E37_79B9;
   end
   // Outside a data phase the bus is not held, so it churns
   assign rom_rdata = ph_ff ? (a_ff ^ 32'hC3A5_0000) : spin_ff;
endmodule : rpu_rom_model

// *** verif/test_rom_patch_unit.sv ***
module test_rom_patch_unit;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rom_rdata, rom_patched_rdata, wd;
   logic [1:0]  htrans;
   logic [7:0]  active_flags;
   logic        ph_ff = 1'b0;
   logic        prom_ff = 1'b0;
   logic [31:0] expq[$];
   logic [31:0] ad[8];
   logic [31:0] dt[8];
   int          failures, n_compared, cyc;
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   rpu_patch_unit #(.N(8)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .rom_rdata(rom_rdata),
      .rom_patched_rdata(rom_patched_rdata), .active_flags(active_flags));
   rpu_rom_model u_rom (.core_clk(core_clk), .haddr(haddr),
      .htrans(htrans), .hready(hreadyout), .rom_rdata(rom_rdata));
   // ****************************************
   // Checking and closing
   // ****************************************
   task close_out();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   function automatic logic [31:0] romw(input logic [31:0] a);
      return a ^ 32'hC3A5_0000;
   endfunction : romw
   // Data phase follows the address phase by one edge
   always @(posedge core_clk) begin
      if (ph_ff && expq.size() > 0)
         chk("read data", prom_ff ? rom_patched_rdata : hrdata,
             expq.pop_front());
      ph_ff   <= rst_n && htrans[1] && !hwrite && hreadyout;
      prom_ff <= !hsel;
      cyc++;
      if (cyc > 4000) begin
         failures++;
         close_out();
      end
   end
   // ****************************************
   // Bus driver
   // ****************************************
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
             input logic [31:0] e);
      hwdata <= wd;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      hsel   <= a[30];
      wd = d;
      if (!w) expq.push_back(e);
      @(posedge core_clk);
   endtask : xfer
   task wr(input logic [9:0] o, input logic [31:0] d);
      xfer(1'b1, rpu_pkg::REG_BASE + {22'h0, o}, d, 32'h0);
   endtask : wr
   task rd(input logic [9:0] o, input logic [31:0] e);
      xfer(1'b0, rpu_pkg::REG_BASE + {22'h0, o}, 32'h0, e);
   endtask : rd
   initial begin
      rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
      hwrite = 1'b0; hwdata = 32'h0; wd = 32'h0;
      failures = 0; n_compared = 0; cyc = 0;
      void'($urandom(32'h587d95de));
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      chk("flags", {24'h0, active_flags}, 32'h0);
      rd(rpu_pkg::OFF_ACTIVE, 32'h0);
      xfer(1'b0, 32'h0000_0100, 32'h0, romw(32'h100));
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         ad[i] = (i < 4 ? 32'h0 : rpu_pkg::ALIAS_BASE) + 32'(i) * 32'h100
                 + ($urandom % 64) * 4;
         dt[i] = $urandom;
         wr(10'(i * 8), ad[i]);
         if (i == 0) rd(rpu_pkg::OFF_ACTIVE, 32'h0);
         wr(10'(i * 8 + 4), dt[i]);
      end
      rd(rpu_pkg::OFF_ACTIVE, 32'hFF);
      for (int i = 0; i < 8; i++) begin
         xfer(1'b0, ad[i], 32'h0, dt[i]);
         rd(10'(i * 8), ad[i]);
      end
      $display("program test done");
      wr(10'h010, ad[5]);
      wr(10'h014, dt[2]);
      xfer(1'b0, ad[5], 32'h0, dt[5]);
      wr(rpu_pkg::OFF_DISABLE, 32'h20);
      rd(rpu_pkg::OFF_ACTIVE, 32'hDF);
      xfer(1'b0, ad[5], 32'h0, dt[2]);
      wr(rpu_pkg::OFF_ENABLE, 32'h20);
      xfer(1'b0, ad[5], 32'h0, dt[5]);
      wr(rpu_pkg::OFF_DISABLE, 32'hFF);
      xfer(1'b0, ad[0], 32'h0, romw(ad[0]));
      rd(rpu_pkg::OFF_ACTIVE, 32'h0);
      rd(10'h04C, 32'h0);
      hwdata <= wd;
      htrans <= 2'h0;
      hsel   <= 1'b0;
      repeat (2) @(posedge core_clk);
      $display("priority test done");
      close_out();
   end
endmodule : test_rom_patch_unit
